// ===== test/ebimux_mem_model.sv
// Behavioural external memory that answers reads on the shared data pins.
`timescale 1ns/1ps

module ebimux_mem_model #(
  parameter logic [31:0] MEM_WORD = 32'h5a3c96e1
) (
  // Pins of the multiplexer
  input wire logic clock,
  input wire ebimux_pkg::ebimux_pins_s pins,
  // Level seen on the data pins
  output logic [31:0] pin_data
);
  logic [31:0] last_q = 32'h0;
  logic selected;
  // The bus has no pull, so a released line shows the inverse of its last level.
  assign selected = (pins.chip_select_n != 6'h3f) || !pins.flash_chip_select_n;
  always_comb begin
    for (int b = 0; b < 32; b++) begin
      if (pins.data_oe[b]) begin
        pin_data[b] = pins.data_out[b];
      end else begin
        pin_data[b] = selected ? MEM_WORD[b] : ~last_q[b];
      end
    end
  end
  always @(posedge clock) begin
    last_q <= pin_data;
  end
endmodule

// ===== test/test_ebimux_top.sv
// Self-checking bench of the external bus pin multiplexer.
`timescale 1ns/1ps

module test_ebimux_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clock_enable = 1'b1;
  ebimux_pkg::ebimux_cfg_s cfg_in = '0;
  ebimux_pkg::ebimux_static_s st = '0;
  ebimux_pkg::ebimux_dram_s dr = '0;
  ebimux_pkg::ebimux_nand_s nd = '0;
  ebimux_pkg::ebimux_pins_s pins;
  ebimux_pkg::ebimux_owner_e owner;
  ebimux_pkg::ebimux_cfg_s cfg_state;
  logic [31:0] pin_data;
  logic [31:0] read_data;
  logic [15:0] nand_read_data;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  ebimux_top i_ebimux_top (.clock(clock), .resetn(resetn), .clock_enable(clock_enable),
    .cfg_in(cfg_in), .static_in(st), .dram_in(dr), .nand_in(nd), .pin_data_in(pin_data),
    .pins(pins), .owner(owner), .cfg_state(cfg_state), .read_data(read_data),
    .nand_read_data(nand_read_data));
  ebimux_mem_model i_ebimux_mem_model (.clock(clock), .pins(pins), .pin_data(pin_data));

  initial forever #50 clock = ~clock;

  task stop_test();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles > 2000) begin
      mismatches++;
      stop_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Registers a configuration, lets it settle, then applies one request.
  task go(input logic [3:0] c, input ebimux_pkg::ebimux_static_s s,
      input ebimux_pkg::ebimux_dram_s d, input ebimux_pkg::ebimux_nand_s n);
    @(posedge clock);
    cfg_in <= c;
    repeat (2) @(posedge clock);
    st <= s;
    dr <= d;
    nd <= n;
    @(posedge clock);
    #1;
  endtask

  initial begin
    ebimux_pkg::ebimux_static_s si;
    ebimux_pkg::ebimux_static_s s;
    ebimux_pkg::ebimux_dram_s di;
    ebimux_pkg::ebimux_dram_s d;
    ebimux_pkg::ebimux_nand_s ni;
    ebimux_pkg::ebimux_nand_s n;
    si = '0;
    si.chip_select_n = 6'h3f;
    si.byte_write_strobe_n = 4'hf;
    di = '0;
    di.dram_chip_select_n = 1'b1;
    di.byte_lane_mask_n = 4'hf;
    ni = '0;
    ni.flash_chip_select_n = 1'b1;
    st = si;
    dr = di;
    nd = ni;
    repeat (5) @(posedge clock);
    #1;
    chk(32'(pins.chip_select_n), 32'h3f, "reset cs");
    chk(32'(pins.flash_chip_select_n), 32'h1, "reset flash cs");
    chk(32'(pins.byte_write_strobe_n), 32'hf, "reset strobes");
    chk(32'(cfg_state), 32'h0, "reset cfg");
    @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      s = si;
      s.active = 1'b1;
      s.chip_select_n = ~(6'h01 << i);
      s.addr = 26'h3ffffff ^ 26'(i);
      s.byte_write_strobe_n = 4'hd;
      go(4'h0, s, di, ni);
      chk(32'(pins.chip_select_n), 32'h3f ^ (32'h1 << i), "static cs");
      chk(32'(pins.addr), 32'(26'h3ffffff ^ 26'(i)), "static addr");
      chk(32'(pins.byte_write_strobe_n), 32'hd, "static strobe");
      chk(32'(owner), 32'(ebimux_pkg::ebimux_owner_static), "static owner");
    end
    repeat (3) @(posedge clock);
    #1;
    chk(read_data, i_ebimux_mem_model.MEM_WORD, "read data");
    d = di;
    d.active = 1'b1;
    d.dram_chip_select_n = 1'b0;
    d.addr = 14'h2d5a;
    d.byte_lane_mask_n = 4'h5;
    go(4'h0, si, d, ni);
    chk(32'(pins.chip_select_n), 32'h3f, "dram refused");
    go(4'h2, s, d, ni);
    chk(32'(owner), 32'(ebimux_pkg::ebimux_owner_dram), "dram owner");
    chk(32'(pins.chip_select_n), 32'h3d, "dram cs");
    chk(32'(pins.addr), 32'h0000a568, "dram addr");
    chk(32'(pins.dram_address10_pin), 32'h1, "dram a10");
    chk(32'(pins.byte_write_strobe_n), 32'h5, "dram mask");
    for (int l = 0; l < 2; l++) begin
      n = ni;
      n.active = 1'b1;
      n.wdata = 16'ha5c3;
      n.data_oe = 1'b1;
      n.flash_chip_select_n = 1'b0;
      go(l[0] ? 4'h5 : 4'h1, si, di, n);
      chk(32'(pins.flash_chip_select_n), 32'h0, "flash cs");
      chk(32'(pins.chip_select_n), 32'h37, "nand cs3");
      chk(pins.data_out, l[0] ? 32'ha5c30000 : 32'h0000a5c3, "nand lane");
      chk(pins.data_oe, l[0] ? 32'hffff0000 : 32'h0000ffff, "nand oe");
      repeat (3) @(posedge clock);
      #1;
      chk(32'(nand_read_data), 32'ha5c3, "nand read lane");
    end
    go(4'h2, si, di, n);
    chk(32'(pins.flash_chip_select_n), 32'h1, "nand refused");
    chk(32'(pins.chip_select_n), 32'h3f, "nand refused cs");
    s.chip_select_n = 6'h3d;
    @(posedge clock);
    clock_enable <= 1'b0;
    st <= s;
    nd <= ni;
    repeat (2) @(posedge clock);
    #1;
    chk(32'(owner), 32'(ebimux_pkg::ebimux_owner_idle), "frozen owner");
    @(posedge clock);
    clock_enable <= 1'b1;
    @(posedge clock);
    #1;
    chk(32'(owner), 32'(ebimux_pkg::ebimux_owner_static), "owner after freeze");
    chk(32'(pins.chip_select_n), 32'h3f, "static cs1 held off");
    go(4'ha, si, di, ni);
    chk(32'(cfg_state), 32'ha, "multiport");
    stop_test();
  end
endmodule

// ===== verilog/ebimux_defines.svh
// Constants of the external bus pin multiplexer.
`ifndef EBIMUX_DEFINES_SVH
`define EBIMUX_DEFINES_SVH
`define EBIMUX_NUM_CS 6
`define EBIMUX_ADDR_W 26
`define EBIMUX_DATA_W 32
`define EBIMUX_NAND_W 16
`define EBIMUX_DRAM_ADDR_W 14
`define EBIMUX_CS_DRAM 1
`define EBIMUX_CS_NAND 3
`define EBIMUX_CS_IDLE 6'h3f
`define EBIMUX_ADDR_RST 26'h0000000
`define EBIMUX_DATA_RST 32'h00000000
`define EBIMUX_MP_RST 1'h0
`define EBIMUX_LANE_RST 1'h0
`define EBIMUX_CS1_RST 1'h0
`define EBIMUX_CS3_RST 1'h0
`endif

// ===== verilog/ebimux_pkg.sv
// Types of the external bus pin multiplexer.
package ebimux_pkg;
  typedef enum logic [1:0] {
    ebimux_owner_idle,
    ebimux_owner_static,
    ebimux_owner_dram,
    ebimux_owner_nand
  } ebimux_owner_e;
  typedef struct packed {
    logic multiport_enable;
    logic nand_upper_lane_select;
    logic cs1_controller_select;
    logic cs3_nand_logic_enable;
  } ebimux_cfg_s;
  typedef struct packed {
    logic [25:0] addr;
    logic [5:0] chip_select_n;
    logic [3:0] byte_write_strobe_n;
    logic [31:0] wdata;
    logic [31:0] data_oe;
    logic active;
  } ebimux_static_s;
  typedef struct packed {
    logic [13:0] addr;
    logic dram_chip_select_n;
    logic [3:0] byte_lane_mask_n;
    logic [31:0] wdata;
    logic [31:0] data_oe;
    logic active;
  } ebimux_dram_s;
  typedef struct packed {
    logic [15:0] wdata;
    logic data_oe;
    logic flash_chip_select_n;
    logic active;
  } ebimux_nand_s;
  typedef struct packed {
    logic [25:0] addr;
    logic dram_address10_pin;
    logic [5:0] chip_select_n;
    logic flash_chip_select_n;
    logic [3:0] byte_write_strobe_n;
    logic [31:0] data_out;
    logic [31:0] data_oe;
  } ebimux_pins_s;
endpackage

// ===== verilog/ebimux_top.sv
// External bus pin multiplexer sharing pins among three memory controllers.
// Operation
// - Multi-port enable resets to zero; one enables multi-port operation; the code only stores the bit and shows it on cfg_state.
// - Six active-low chip select outputs, each its own address space.
// - Data bus of 16 or 32 bits, address bus up to 26 bits.
// - Each chip select covers a linear range of up to 64 megabytes.
// - Static controller may drive any of chip selects zero to five, except 1 when it is assigned to DRAM.
// - Chip select 1 comes from DRAM select or static controller, as configured.
// - NAND flash is supported only on chip select 3.
// - Three sources are merged: static, DRAM and 16-bit NAND.
// - Shared pins are steered by which controller performs the access.
// - Address pins 11:2 and 15:13 carry DRAM or static address bits.
// - Pins 0, 1, 12, 25:16 static only; address10 pin DRAM only.
// - The flash chip select output is active low.
// - The DRAM chip select output is active low.
// - NAND lane select puts NAND data on pins 15:0 or 31:16.
// - Chip select 1 assignment: zero static, one DRAM.
// - Chip select 3 assignment: one additionally activates NAND logic.
`timescale 1ns/1ps
`include "ebimux_defines.svh"

module ebimux_top (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  // Configuration
  input wire ebimux_pkg::ebimux_cfg_s cfg_in,
  // Controller sources
  input wire ebimux_pkg::ebimux_static_s static_in,
  input wire ebimux_pkg::ebimux_dram_s dram_in,
  input wire ebimux_pkg::ebimux_nand_s nand_in,
  // Data read back from the pins
  input wire logic [31:0] pin_data_in,
  // Pins
  output ebimux_pkg::ebimux_pins_s pins,
  // Status and read data toward the controllers
  output ebimux_pkg::ebimux_owner_e owner,
  output ebimux_pkg::ebimux_cfg_s cfg_state,
  output logic [31:0] read_data,
  output logic [15:0] nand_read_data
);

  ebimux_pkg::ebimux_cfg_s cfg_q, cfg_d;
  ebimux_pkg::ebimux_pins_s pins_q, pins_d;
  ebimux_pkg::ebimux_owner_e owner_q, owner_d;
  logic [31:0] din_meta_q, din_sync_q;
  logic [31:0] rd_q, rd_d;
  logic [15:0] nrd_q, nrd_d;

  // Picks the 16-bit NAND lane out of the 32-bit pin data.
  function automatic logic [15:0] nand_lane(input logic [31:0] d, input logic upper);
    nand_lane = upper ? d[31:16] : d[15:0];
  endfunction

  // Configuration register; captured while the clock enable is high.
  always_comb begin
    cfg_d = cfg_q;
    if (clock_enable) begin
      cfg_d = cfg_in;
    end
  end

  // Owner choice: DRAM only where chip select 1 belongs to it, NAND only on chip select 3.
  always_comb begin
    owner_d = ebimux_pkg::ebimux_owner_idle;
    if (dram_in.active && cfg_q.cs1_controller_select) begin
      owner_d = ebimux_pkg::ebimux_owner_dram;
    end else if (nand_in.active && cfg_q.cs3_nand_logic_enable) begin
      owner_d = ebimux_pkg::ebimux_owner_nand;
    end else if (static_in.active) begin
      owner_d = ebimux_pkg::ebimux_owner_static;
    end
  end

  // Pin steering.
  always_comb begin
    pins_d = '0;
    pins_d.chip_select_n = `EBIMUX_CS_IDLE;
    pins_d.flash_chip_select_n = 1'h1;
    pins_d.byte_write_strobe_n = 4'hf;
    pins_d.addr = `EBIMUX_ADDR_RST;
    pins_d.data_out = `EBIMUX_DATA_RST;
    pins_d.data_oe = 32'h00000000;
    case (owner_d)
      ebimux_pkg::ebimux_owner_static: begin
        pins_d.addr = static_in.addr;
        pins_d.chip_select_n = static_in.chip_select_n;
        if (cfg_q.cs1_controller_select) begin
          pins_d.chip_select_n[`EBIMUX_CS_DRAM] = 1'h1;
        end
        pins_d.byte_write_strobe_n = static_in.byte_write_strobe_n;
        pins_d.data_out = static_in.wdata;
        pins_d.data_oe = static_in.data_oe;
      end
      ebimux_pkg::ebimux_owner_dram: begin
        pins_d.addr[11:2] = dram_in.addr[9:0];
        pins_d.addr[15:13] = dram_in.addr[13:11];
        pins_d.dram_address10_pin = dram_in.addr[10];
        pins_d.chip_select_n[`EBIMUX_CS_DRAM] = dram_in.dram_chip_select_n;
        pins_d.byte_write_strobe_n = dram_in.byte_lane_mask_n;
        pins_d.data_out = dram_in.wdata;
        pins_d.data_oe = dram_in.data_oe;
      end
      ebimux_pkg::ebimux_owner_nand: begin
        pins_d.chip_select_n[`EBIMUX_CS_NAND] = nand_in.flash_chip_select_n;
        pins_d.flash_chip_select_n = nand_in.flash_chip_select_n;
        if (cfg_q.nand_upper_lane_select) begin
          pins_d.data_out[31:16] = nand_in.wdata;
          pins_d.data_oe[31:16] = {16{nand_in.data_oe}};
        end else begin
          pins_d.data_out[15:0] = nand_in.wdata;
          pins_d.data_oe[15:0] = {16{nand_in.data_oe}};
        end
      end
      default: begin
        pins_d.addr = `EBIMUX_ADDR_RST;
      end
    endcase
  end

  // Read data returned from the synchronised pins.
  always_comb begin
    rd_d = din_sync_q;
    nrd_d = nand_lane(din_sync_q, cfg_q.nand_upper_lane_select);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= '0;
      owner_q <= ebimux_pkg::ebimux_owner_idle;
      pins_q <= '{addr: `EBIMUX_ADDR_RST, dram_address10_pin: 1'h0,
                  chip_select_n: `EBIMUX_CS_IDLE, flash_chip_select_n: 1'h1,
                  byte_write_strobe_n: 4'hf, data_out: `EBIMUX_DATA_RST,
                  data_oe: 32'h00000000};
      din_meta_q <= `EBIMUX_DATA_RST;
      din_sync_q <= `EBIMUX_DATA_RST;
      rd_q <= `EBIMUX_DATA_RST;
      nrd_q <= 16'h0000;
    end else if (clock_enable) begin
      cfg_q <= cfg_d;
      owner_q <= owner_d;
      pins_q <= pins_d;
      din_meta_q <= pin_data_in;
      din_sync_q <= din_meta_q;
      rd_q <= rd_d;
      nrd_q <= nrd_d;
    end
  end

  assign pins = pins_q;
  assign owner = owner_q;
  assign cfg_state = cfg_q;
  assign read_data = rd_q;
  assign nand_read_data = nrd_q;

  a_mp_reset: assert property (@(posedge clock) $rose(resetn) |-> !cfg_q.multiport_enable)
    else $error("multiport enable not cleared after reset");
  a_idle_strobes: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_idle |-> pins_q.chip_select_n == 6'h3f
      && pins_q.byte_write_strobe_n == 4'hf && pins_q.data_oe == 32'h0)
    else $error("idle pins not inactive");
  a_dram_addr_map: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && owner_d == ebimux_pkg::ebimux_owner_dram |=>
      pins_q.addr[11:2] == $past(dram_in.addr[9:0])
      && pins_q.dram_address10_pin == $past(dram_in.addr[10])
      && pins_q.addr[15:13] == $past(dram_in.addr[13:11]) && pins_q.addr[12] == 1'h0)
    else $error("dram address mapping wrong");
  a_static_addr: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && owner_d == ebimux_pkg::ebimux_owner_static |=>
      pins_q.addr == $past(static_in.addr) && pins_q.dram_address10_pin == 1'h0)
    else $error("static address not passed");
  a_cs1_static: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_static && cfg_q.cs1_controller_select
      |-> pins_q.chip_select_n[1])
    else $error("static drove chip select 1 assigned to dram");
  a_dram_needs_cs1: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_dram |-> $past(cfg_q.cs1_controller_select))
    else $error("dram owned pins without chip select 1");
  a_nand_cs3_only: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_nand |-> pins_q.chip_select_n[5:4] == 2'h3
      && pins_q.chip_select_n[2:0] == 3'h7 && $past(cfg_q.cs3_nand_logic_enable))
    else $error("nand outside chip select 3");
  a_nand_lane: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_nand && $past(cfg_q.nand_upper_lane_select)
      |-> pins_q.data_oe[15:0] == 16'h0000)
    else $error("nand lower lane driven while upper selected");

  // Checks on chip selects, strobes, address and data while each owner holds the pins.
  a_flash_cs_idle: assert property (@(posedge clock) disable iff (!resetn)
    owner_q != ebimux_pkg::ebimux_owner_nand |-> pins_q.flash_chip_select_n)
    else $error("flash chip select active without nand owner");

  a_flash_cs_follow: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_nand
      |-> pins_q.flash_chip_select_n == pins_q.chip_select_n[3])
    else $error("flash chip select differs from chip select 3");

  a_dram_cs_only: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_dram
      |-> pins_q.chip_select_n[5:2] == 4'hf && pins_q.chip_select_n[0])
    else $error("dram owner drove a chip select other than 1");

  a_dram_cs_map: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && owner_d == ebimux_pkg::ebimux_owner_dram
      |=> pins_q.chip_select_n[1] == $past(dram_in.dram_chip_select_n))
    else $error("dram chip select not on chip select 1");

  a_dram_mask_map: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && owner_d == ebimux_pkg::ebimux_owner_dram
      |=> pins_q.byte_write_strobe_n == $past(dram_in.byte_lane_mask_n))
    else $error("dram byte mask not on the strobe pins");

  a_dram_static_pins: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_dram
      |-> pins_q.addr[25:16] == 10'h000 && pins_q.addr[1:0] == 2'h0)
    else $error("dram owner drove static only address pins");

  a_static_cs_map: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && owner_d == ebimux_pkg::ebimux_owner_static && !cfg_q.cs1_controller_select
      |=> pins_q.chip_select_n == $past(static_in.chip_select_n))
    else $error("static chip selects not passed");

  a_static_strobe: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && owner_d == ebimux_pkg::ebimux_owner_static
      |=> pins_q.byte_write_strobe_n == $past(static_in.byte_write_strobe_n))
    else $error("static write strobes not passed");

  a_static_data: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && owner_d == ebimux_pkg::ebimux_owner_static
      |=> pins_q.data_oe == $past(static_in.data_oe)
      && pins_q.data_out == $past(static_in.wdata))
    else $error("static data not passed");

  a_nand_quiet: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_nand
      |-> pins_q.byte_write_strobe_n == 4'hf && pins_q.addr == 26'h0000000)
    else $error("nand owner drove strobes or address");

  a_nand_upper_off: assert property (@(posedge clock) disable iff (!resetn)
    owner_q == ebimux_pkg::ebimux_owner_nand && !$past(cfg_q.nand_upper_lane_select)
      |-> pins_q.data_oe[31:16] == 16'h0000)
    else $error("nand upper lane driven while lower selected");

  // Freezing must hold every register, so a paused bus never glitches.
  a_freeze_hold: assert property (@(posedge clock) disable iff (!resetn)
    !clock_enable |=> $stable(pins_q) && $stable(owner_q) && $stable(cfg_q))
    else $error("state moved while clock enable low");

  a_cfg_capture: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable |=> cfg_q == $past(cfg_in))
    else $error("configuration not captured");

  a_dram_priority: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && dram_in.active && cfg_q.cs1_controller_select
      |=> owner_q == ebimux_pkg::ebimux_owner_dram)
    else $error("dram request lost its priority");

  a_nand_refused: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && !cfg_q.cs3_nand_logic_enable
      |=> owner_q != ebimux_pkg::ebimux_owner_nand)
    else $error("nand owned pins without nand logic enabled");

  a_read_path: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable |=> rd_q == $past(din_sync_q))
    else $error("read data not taken from synchronised pins");

  a_nand_read_lane: assert property (@(posedge clock) disable iff (!resetn)
    clock_enable && cfg_q.nand_upper_lane_select |=> nrd_q == $past(din_sync_q[31:16]))
    else $error("nand read data not from the upper lane");

  c_static: cover property (@(posedge clock) owner_q == ebimux_pkg::ebimux_owner_static);
  c_dram: cover property (@(posedge clock) owner_q == ebimux_pkg::ebimux_owner_dram);
  c_nand_up: cover property (@(posedge clock)
    owner_q == ebimux_pkg::ebimux_owner_nand && cfg_q.nand_upper_lane_select);
  c_mp: cover property (@(posedge clock) cfg_q.multiport_enable);
  c_frozen: cover property (@(posedge clock) resetn && !clock_enable);

endmodule
